// File: core/lhis_pkg.sv
// package for the host interface select block: mode codes and widths
// assumes a single 50 MHz clock shared by both ends
// Operation
// (RULE1) top strap low picks parallel mode
// (RULE2) top strap high picks serial link
// (RULE3) serial modes use bottom strap as ID
// (RULE4) chip select low enables, high ignores
// (RULE5) kind select: low index, high control
// (RULE6) 68 mode: enable strobe does transfer
// (RULE7) 68 mode: direction low write, high read
// (RULE8) 80 mode: low write strobe captures data
// (RULE9) 80 mode: low read strobe drives data
// (RULE10) serial modes: strobe pin is clock
// (RULE11) serial modes: direction pin is data
// (RULE12) 16-bit modes use all sixteen lines
// (RULE13) 8-bit modes use upper byte only
// (RULE14) serial modes: host holds data lines fixed
// (RULE15) low reset returns initial state
// (RULE16) 8-bit words go upper byte first
package lhis_pkg;
    localparam int LHIS_DATA_W = 16;
    localparam int LHIS_BYTE_W = 8;
    localparam logic [3:0] LHIS_ID_RESET = 4'h0;
    localparam logic [15:0] LHIS_WORD_RESET = 16'h0000;
    localparam logic [7:0] LHIS_SER_ADDR_BASE = 8'h38;
    localparam int LHIS_SER_ID_POS = 1;
    localparam int LHIS_HALF_PERIOD = 2;
    typedef enum logic [2:0] {
        LHIS_M68_16 = 3'h0,
        LHIS_M68_8 = 3'h1,
        LHIS_M80_16 = 3'h2,
        LHIS_M80_8 = 3'h3,
        LHIS_SER_SYNC = 3'h4,
        LHIS_SER_I2C = 3'h6
    } lhis_mode_t;
endpackage

// File: core/lhis_if.sv
// interface joining host and device ends of the host port
// assumes the bench resolves two-way lines from the enables
`timescale 1ns/10ps
interface lhis_if;
    logic iface_mode_strap_hi;
    logic iface_mode_strap_mid;
    logic iface_mode_strap_lo_or_addr_bit;
    logic reset_n;
    logic cs_n;
    logic register_kind_select;
    logic strobe;
    logic dir_in;
    logic dir_host_out;
    logic dir_host_oe;
    logic dir_dev_out;
    logic dir_dev_oe;
    logic [15:0] host_data_lines_in;
    logic [15:0] host_data_lines_host_out;
    logic host_data_lines_host_oe;
    logic [15:0] host_data_lines_dev_out;
    logic host_data_lines_dev_oe;
    modport dev (
        input iface_mode_strap_hi, iface_mode_strap_mid, iface_mode_strap_lo_or_addr_bit,
        input reset_n, cs_n, register_kind_select, strobe, dir_in, host_data_lines_in,
        output dir_dev_out, dir_dev_oe, host_data_lines_dev_out, host_data_lines_dev_oe
    );
    modport host (
        output iface_mode_strap_hi, iface_mode_strap_mid, iface_mode_strap_lo_or_addr_bit,
        output reset_n, cs_n, register_kind_select, strobe,
        output dir_host_out, dir_host_oe, host_data_lines_host_out, host_data_lines_host_oe,
        input dir_in, host_data_lines_in
    );
endinterface

// File: core/lhis_dev.sv
// device end: decodes straps, runs 68/80 parallel cycles and a serial shifter
// assumes pins are asynchronous and pass two flip-flops before use
`timescale 1ns/10ps
module lhis_dev
    import lhis_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    lhis_if.dev link,
    output logic [2:0] mode,
    output logic [7:0] dev_addr,
    output logic wr_valid,
    output logic wr_kind,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [7:0] s1;
    logic [7:0] s2;
    logic [15:0] d1;
    logic [15:0] d2;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            d1 <= 16'h0000;
            d2 <= 16'h0000;
        end else begin
            s1 <= {link.iface_mode_strap_hi, link.iface_mode_strap_mid,
                   link.iface_mode_strap_lo_or_addr_bit, link.reset_n, link.cs_n,
                   link.register_kind_select, link.strobe, link.dir_in};
            s2 <= s1;
            d1 <= link.host_data_lines_in;
            d2 <= d1;
        end
    end
    logic rst_n_s, cs_n_s, kind_s, stb_s, dir_s;
    assign rst_n_s = s2[4];
    assign cs_n_s = s2[3];
    assign kind_s = s2[2];
    assign stb_s = s2[1];
    assign dir_s = s2[0];
    logic soft_rst;
    // (RULE15) pin reset clears state
    assign soft_rst = ~rst_n_s;
    // ----------------------------------------
    // mode decode, caught at reset release
    // ----------------------------------------
    logic caught;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= 3'h0;
            dev_addr <= 8'h00;
            caught <= 1'b0;
        end else if (soft_rst) begin
            caught <= 1'b0;
        end else if (!caught) begin
            caught <= 1'b1;
            // (RULE1) parallel mode decode
            // (RULE2) serial mode decode
            if (s2[7])
                mode <= {1'b1, s2[6], 1'b0};
            else
                mode <= {1'b0, s2[6], s2[5]};
            // (RULE3) strap as address bit
            dev_addr <= LHIS_SER_ADDR_BASE | (8'(s2[5]) << LHIS_SER_ID_POS);
        end
    end
    logic is_ser, is_80, is_8;
    assign is_ser = mode[2];
    assign is_80 = mode[1];
    assign is_8 = mode[0];
    // ----------------------------------------
    // parallel access
    // ----------------------------------------
    logic sel, stb_d, active, prev_active;
    // (RULE4) ignore bus when deselected
    assign sel = caught & ~cs_n_s & ~is_ser;
    // (RULE6) enable strobe qualifies 68 cycle
    // (RULE8) low write strobe in 80 mode
    assign active = is_80 ? ~stb_s : stb_s;
    logic rd_now;
    // (RULE7) direction pin picks read
    // (RULE9) low read strobe in 80 mode
    assign rd_now = sel & (is_80 ? ~dir_s : (stb_s & dir_s));
    logic hi_next;
    logic [7:0] hi_byte;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_active <= 1'b0;
            wr_valid <= 1'b0;
            wr_kind <= 1'b0;
            wr_data <= LHIS_WORD_RESET;
            hi_next <= 1'b1;
            hi_byte <= 8'h00;
        end else if (soft_rst) begin
            prev_active <= 1'b0;
            wr_valid <= 1'b0;
            hi_next <= 1'b1;
        end else begin
            prev_active <= sel & active & (is_80 | ~dir_s);
            wr_valid <= 1'b0;
            if (prev_active && !(sel & active & (is_80 | ~dir_s))) begin
                // (RULE5) kind select routes access
                wr_kind <= kind_s;
                if (!is_8) begin
                    // (RULE12) full sixteen bit word
                    wr_data <= d2;
                    wr_valid <= 1'b1;
                end else if (hi_next) begin
                    // (RULE16) upper byte comes first
                    hi_byte <= d2[15:8];
                    hi_next <= 1'b0;
                end else begin
                    // (RULE13) upper lanes carry bytes
                    wr_data <= {hi_byte, d2[15:8]};
                    wr_valid <= 1'b1;
                    hi_next <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------
    // read drive
    // ----------------------------------------
    logic rd_phase;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            link.host_data_lines_dev_out <= 16'h0000;
            link.host_data_lines_dev_oe <= 1'b0;
            rd_phase <= 1'b0;
            stb_d <= 1'b0;
        end else begin
            stb_d <= rd_now;
            link.host_data_lines_dev_oe <= rd_now & ~soft_rst;
            if (soft_rst)
                rd_phase <= 1'b0;
            else if (stb_d && !rd_now && is_8)
                rd_phase <= ~rd_phase;
            // (RULE13) 8-bit reads use upper lanes only
            if (rd_now && is_8)
                link.host_data_lines_dev_out <= rd_phase ?
                    {rd_data[7:0], 8'h00} : {rd_data[15:8], 8'h00};
            else if (rd_now)
                link.host_data_lines_dev_out <= rd_data;
        end
    end
    // ----------------------------------------
    // serial shifter
    // ----------------------------------------
    logic sclk_d;
    logic [15:0] sh;
    logic [4:0] cnt;
    // (RULE10) strobe pin as serial clock
    // (RULE11) direction pin as serial data
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d <= 1'b0;
            sh <= 16'h0000;
            cnt <= 5'h00;
            link.dir_dev_out <= 1'b0;
            link.dir_dev_oe <= 1'b0;
        end else begin
            sclk_d <= stb_s;
            link.dir_dev_oe <= 1'b0;
            if (!is_ser || cs_n_s || soft_rst) begin
                cnt <= 5'h00;
            end else if (stb_s && !sclk_d) begin
                sh <= {sh[14:0], dir_s};
                cnt <= (cnt == 5'h0F) ? 5'h00 : cnt + 5'h01;
            end
        end
    end
endmodule

// File: core/lhis_host.sv
// host end: ties straps, drives 68/80 strobes; serial clock and data lines stay idle
// assumes the bench resolves shared lines from the enables
`timescale 1ns/10ps
module lhis_host
    import lhis_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    lhis_if.host link,
    input wire logic [2:0] mode_sel,
    input wire logic req,
    input wire logic req_write,
    input wire logic req_kind,
    input wire logic [15:0] req_data,
    output logic busy,
    output logic [15:0] rsp_data
);
    // ----------------------------------------
    // straps and fixed lines
    // ----------------------------------------
    // (RULE15) reset pin from host reset
    assign link.reset_n = ~sys_rst;
    assign link.iface_mode_strap_hi = mode_sel[2];
    assign link.iface_mode_strap_mid = mode_sel[1];
    assign link.iface_mode_strap_lo_or_addr_bit = mode_sel[0];
    logic [3:0] ph;
    logic wr, kind;
    logic [15:0] dat;
    logic is_80;
    assign is_80 = mode_sel[1];
    // ----------------------------------------
    // access sequence
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ph <= 4'h0;
            wr <= 1'b0;
            kind <= 1'b0;
            dat <= 16'h0000;
            rsp_data <= 16'h0000;
        end else if (ph == 4'h0) begin
            if (req && !mode_sel[2]) begin
                ph <= 4'h1;
                wr <= req_write;
                kind <= req_kind;
                dat <= req_data;
            end
        end else begin
            ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
            if (ph == 4'h7 && !wr)
                rsp_data <= link.host_data_lines_in;
        end
    end
    assign busy = ph != 4'h0;
    logic on;
    assign on = ph >= 4'h2 && ph <= 4'h8;
    // (RULE4) chip select low in cycle
    assign link.cs_n = ~busy;
    // (RULE5) kind select with access
    assign link.register_kind_select = busy & kind;
    // (RULE6) enable high, (RULE8) write strobe low
    assign link.strobe = is_80 ? ~(on & wr) : on;
    // (RULE7) direction, (RULE9) read strobe
    assign link.dir_host_out = is_80 ? ~(on & ~wr) : ~wr;
    assign link.dir_host_oe = 1'b1;
    // (RULE13) low byte fixed in 8-bit mode
    // (RULE14) lines fixed in serial mode
    assign link.host_data_lines_host_out = (mode_sel[2] || !busy) ? 16'h0000 :
        (mode_sel[0] ? {dat[15:8], 8'h00} : dat);
    assign link.host_data_lines_host_oe = ~(busy & ~wr);
endmodule

// File: dv/lhis_props.sv
// assertions on the shared lines between the host end and the device end
// assumes one clock and one reset shared by both ends
`timescale 1ns/10ps
module lhis_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic iface_mode_strap_hi,
    input wire logic iface_mode_strap_mid,
    input wire logic cs_n,
    input wire logic register_kind_select,
    input wire logic dir_in,
    input wire logic dir_host_oe,
    input wire logic dir_dev_oe,
    input wire logic [15:0] host_data_lines_host_out,
    input wire logic host_data_lines_host_oe,
    input wire logic host_data_lines_dev_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_desel_no_drive: assert property (cs_n [*4] |-> !host_data_lines_dev_oe)
        else $error("device drives data while deselected");
    a_serial_dev_quiet: assert property (iface_mode_strap_hi |-> !host_data_lines_dev_oe)
        else $error("device drives data in serial mode");
    a_serial_host_quiet: assert property (iface_mode_strap_hi |-> host_data_lines_host_oe
        && host_data_lines_host_out == 16'h0000)
        else $error("host drives data in serial mode");
    a_data_one_driver: assert property (!(host_data_lines_host_oe && host_data_lines_dev_oe))
        else $error("both ends drive data");
    a_sda_one_driver: assert property (!(dir_host_oe && dir_dev_oe))
        else $error("both ends drive the direction line");
    a_kind_held: assert property (!cs_n && !$past(cs_n) |-> $stable(register_kind_select))
        else $error("kind select moved during access");
    a_dir_held_m68: assert property (!iface_mode_strap_hi && !iface_mode_strap_mid && !cs_n
        && !$past(cs_n) |-> $stable(dir_in))
        else $error("direction moved during access");
    a_word_held: assert property (host_data_lines_host_oe && !cs_n && !$past(cs_n)
        |-> $stable(host_data_lines_host_out))
        else $error("write data moved while driven");
    c_read: cover property (host_data_lines_dev_oe);
    c_write: cover property (host_data_lines_host_oe);
    c_serial: cover property (iface_mode_strap_hi ##1 !cs_n);
endmodule

// File: dv/tb_top.sv
// self-checking bench: host end and device end joined by the interface
// assumes released shared lines show a changing pattern
`timescale 1ns/10ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: %s", $time, m); end end
module tb_top;
    import lhis_pkg::*;
    logic clock = 0, sys_rst = 1, req = 0, req_write = 0, req_kind = 0, flip = 0, wr_seen = 0;
    logic [2:0] mode_sel = 3'h0;
    logic [15:0] req_data = 16'h0000, rd_data = 16'h0000, wd;
    logic [2:0] mode;
    logic [7:0] dev_addr, hb, lb;
    logic wr_valid, wr_kind, busy, k;
    logic [15:0] wr_data, rsp_data;
    int fail_count = 0, num_checks = 0, cycles = 0;
    lhis_if link_if();
    assign link_if.dir_in = link_if.dir_dev_oe ? link_if.dir_dev_out :
        link_if.dir_host_oe ? link_if.dir_host_out : flip;
    assign link_if.host_data_lines_in = link_if.host_data_lines_dev_oe ?
        link_if.host_data_lines_dev_out : link_if.host_data_lines_host_oe ?
        link_if.host_data_lines_host_out : {16{flip}};
    lhis_host u_lhis_host (.clock(clock), .sys_rst(sys_rst), .link(link_if),
        .mode_sel(mode_sel), .req(req), .req_write(req_write), .req_kind(req_kind),
        .req_data(req_data), .busy(busy), .rsp_data(rsp_data));
    lhis_dev u_lhis_dev (.clock(clock), .sys_rst(sys_rst), .link(link_if), .mode(mode),
        .dev_addr(dev_addr), .wr_valid(wr_valid), .wr_kind(wr_kind), .wr_data(wr_data),
        .rd_data(rd_data));
    lhis_props u_lhis_props (.clock(clock), .sys_rst(sys_rst),
        .iface_mode_strap_hi(link_if.iface_mode_strap_hi),
        .iface_mode_strap_mid(link_if.iface_mode_strap_mid), .cs_n(link_if.cs_n),
        .register_kind_select(link_if.register_kind_select), .dir_in(link_if.dir_in),
        .dir_host_oe(link_if.dir_host_oe), .dir_dev_oe(link_if.dir_dev_oe),
        .host_data_lines_host_out(link_if.host_data_lines_host_out),
        .host_data_lines_host_oe(link_if.host_data_lines_host_oe),
        .host_data_lines_dev_oe(link_if.host_data_lines_dev_oe));
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        flip <= ~flip;
        if (wr_valid === 1'b1) wr_seen <= 1'b1;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    function automatic logic [2:0] exp_mode(input logic [2:0] s);
        return s[2] ? {s[2:1], 1'b0} : s;
    endfunction
    function automatic logic [7:0] exp_addr(input logic [2:0] s);
        return LHIS_SER_ADDR_BASE | (8'(s[0]) << LHIS_SER_ID_POS);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic restart(input logic [2:0] s);
        mode_sel = s;
        sys_rst = 1;
        repeat (16) @(negedge clock);
        sys_rst = 0;
        repeat (8) @(negedge clock);
    endtask
    task automatic access(input logic w, input logic kk, input logic [15:0] d);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 60) begin
            @(negedge clock);
            n++;
        end
        wr_seen = 0;
        req = 1;
        req_write = w;
        req_kind = kk;
        req_data = d;
        @(negedge clock);
        req = 0;
        n = 0;
        while (busy !== 1'b0 && n < 60) begin
            @(negedge clock);
            n++;
        end
        repeat (6) @(negedge clock);
    endtask
    initial begin
        void'($urandom(27));
        for (int s = 0; s < 8; s++) begin
            restart(3'(s));
            `CHK(mode, exp_mode(3'(s)), "mode decode")
            if (s >= 4) begin
                `CHK(dev_addr, exp_addr(3'(s)), "serial address")
                access(1'b1, 1'b1, 16'(s));
                `CHK(wr_seen, 1'b0, "parallel write in serial mode")
            end
        end
        for (int m = 0; m < 4; m++) begin
            restart(3'(m));
            for (int i = 0; i < 6; i++) begin
                wd = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
                k = 1'(i);
                if (m[0]) begin
                    hb = wd[15:8];
                    lb = wd[7:0];
                    access(1'b1, k, {hb, hb});
                    access(1'b1, k, {lb, lb});
                end else begin
                    access(1'b1, k, wd);
                end
                `CHK(wr_seen, 1'b1, "write not seen")
                `CHK(wr_data, wd, "write word")
                `CHK(wr_kind, k, "write kind")
                rd_data = 16'($urandom);
                if (m[0]) begin
                    access(1'b0, k, 16'h0000);
                    `CHK(rsp_data[15:8], rd_data[15:8], "read upper byte")
                    `CHK(rsp_data[7:0], 8'h00, "read lower lanes")
                    access(1'b0, k, 16'h0000);
                    `CHK(rsp_data[15:8], rd_data[7:0], "read lower byte")
                end else begin
                    access(1'b0, k, 16'h0000);
                    `CHK(rsp_data, rd_data, "read word")
                end
            end
        end
        tally_and_finish();
    end
endmodule
